// *** mrs_ctl.sv ***
`timescale 1ns/100ps
module mrs_ctl #(
  parameter HOLD = 500000
) (
  input wire clk,
  input wire rstn,
  input wire [5:0] i_want,
  output reg [5:0] o_lvl
);
  // each applied level stays at least HOLD cycles
  integer cnt_q;
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      o_lvl <= 6'h00;
      cnt_q <= 0;
    end
    else if (cnt_q < HOLD)
      cnt_q <= cnt_q + 1;
    else if (i_want != o_lvl)
    begin
      o_lvl <= i_want;
      cnt_q <= 0;
    end
  end
endmodule // mrs_ctl

// *** mrs_ramp.v ***
`timescale 1ns/100ps
`include "mrs_regs.vh"
module mrs_ramp #(
  parameter W = 12
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_run,
  input wire i_decel,
  input wire i_brake,
  input wire [W-1:0] i_target,
  input wire [7:0] i_acc_t,
  input wire [7:0] i_dec_t,
  output reg [W-1:0] o_speed,
  output wire o_zero
);
  localparam integer STEP_CYC = `MRS_STEP_US * `MRS_CLK_MHZ;
  reg [9:0] tick_q;
  reg [11:0] acc_q;
  wire tick = (tick_q == STEP_CYC[9:0] - 10'h001);
  wire [W-1:0] goal = i_run ? i_target : {W{1'b0}};
  wire up = goal > o_speed;
  wire [7:0] t_raw = up ? i_acc_t : i_dec_t;
  wire [7:0] t_sel = (t_raw == 8'h00) ? 8'h01 : t_raw;
  wire [19:0] lim_w = t_sel * `MRS_TIME_SCALE;
  wire [11:0] lim = lim_w[11:0];
  wire [11:0] acc_n = acc_q + `MRS_RATE_NUM;
  assign o_zero = (o_speed == {W{1'b0}});
  always @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      tick_q <= 10'h000;
      acc_q <= 12'h000;
      o_speed <= {W{1'b0}};
    end
    else
    begin
      tick_q <= tick ? 10'h000 : tick_q + 10'h001;
      if (i_brake)
      begin
        o_speed <= {W{1'b0}};
        acc_q <= 12'h000;
      end
      else if (!(i_run || i_decel) || goal == o_speed)
        acc_q <= 12'h000;
      else if (tick)
      begin
        if (acc_n >= lim)
        begin
          acc_q <= acc_n - lim;
          o_speed <= up ? o_speed + 1'b1 : o_speed - 1'b1;
        end
        else
          acc_q <= acc_n;
      end
    end
  end
endmodule // mrs_ramp

// *** mrs_regs.vh ***
`ifndef MRS_REGS_VH
`define MRS_REGS_VH
// register byte addresses
`define MRS_ADDR_CTRL 8'h00
`define MRS_ADDR_OFFSET 8'h04
`define MRS_ADDR_ACCEL 8'h08
`define MRS_ADDR_STATUS 8'h0C
`define MRS_ADDR_SPEED 8'h10
`define MRS_ADDR_DATA 8'h20
`define MRS_ADDR_DATA_END 8'h3C
// control fields
`define MRS_CTRL_DIR 0
`define MRS_CTRL_PWM 1
`define MRS_CTRL_SEL_LSB 2
`define MRS_CTRL_SEL_MSB 4
`define MRS_CTRL_TL_LSB 5
`define MRS_CTRL_TL_MSB 6
`define MRS_CTRL_RST 7'h0D
`define MRS_ACCEL_RST 8'h01
// operation data entry fields
`define MRS_ENT_SPD_LSB 0
`define MRS_ENT_SPD_MSB 11
`define MRS_ENT_DEC_LSB 12
`define MRS_ENT_DEC_MSB 19
`define MRS_ENT_TQ_LSB 20
`define MRS_ENT_TQ_MSB 27
`define MRS_ENT_SM_LSB 28
`define MRS_ENT_SM_MSB 29
`define MRS_ENT_TM_LSB 30
`define MRS_ENT_TM_MSB 31
`define MRS_ENT0_RST 32'h36401000
`define MRS_ENT1_RST 32'h16401000
`define MRS_ENTN_RST 32'h06401000
// setting methods
`define MRS_M_DIG 2'h0
`define MRS_M_POT1 2'h1
`define MRS_M_POT2 2'h2
`define MRS_M_EXT 2'h3
// limits
`define MRS_SPD_MAX 12'hFA0
`define MRS_OFS_MAX 12'h5DC
`define MRS_OFS_MIN 12'hA24
`define MRS_TQ_MAX 8'hC8
// ramp timing: one step slot per 10 us, 3000 r/min per 0.1 s unit
`define MRS_CLK_MHZ 50
`define MRS_STEP_US 10
`define MRS_RATE_NUM 12'h003
`define MRS_TIME_SCALE 12'h00A
`endif

// *** mrs_top.v ***
`timescale 1ns/100ps
`include "mrs_regs.vh"
module mrs_top #(
  parameter N_ENT = 8,
  parameter N_TL = 2
) (
  input wire I_CLK,
  input wire I_RSTN,
  input wire I_RUN_REQUEST,
  input wire I_RUN_PERMIT_INPUT,
  input wire [2:0] I_SPEED_SELECT,
  input wire I_DIRECTION_INPUT,
  input wire [N_TL-1:0] I_TORQUE_LIMIT_ENABLE_INPUT,
  input wire [11:0] I_EXT_ANALOG_SPEED,
  input wire [11:0] I_EXT_PWM_SPEED,
  input wire [11:0] I_EXT_TORQUE_VOLT,
  input wire [11:0] I_INTERNAL_POT_FIRST,
  input wire [11:0] I_INTERNAL_POT_SECOND,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [7:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output reg [31:0] O_PRDATA,
  output wire O_PREADY,
  output wire O_PSLVERR,
  output wire [11:0] O_SPEED_CMD,
  output reg O_DIR_CW,
  output reg O_BRAKE,
  output reg [1:0] O_RUN_STATE,
  output reg [2:0] O_OP_DATA_NUM,
  output reg [7:0] O_TORQUE_LIMIT_PCT,
  output reg O_TORQUE_LIMIT_ACTIVE,
  output reg O_SETTING_ERROR
);
  localparam [1:0] ST_STOP = 2'b00;
  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_DECEL = 2'b10;
  localparam [1:0] ST_BRAKE = 2'b11;

  reg [6:0] ctrl_q;
  reg [11:0] ofs_q;
  reg [7:0] acc_t_q;
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [11:0] spd_base;
  reg [11:0] spd_tgt;
  reg [7:0] tq_d;
  reg [31:0] rd_d;
  reg [11:0] ofs_w;
  wire [11:0] speed_now;
  wire speed_zero;
  wire [31:0] ent_flat [0:N_ENT-1];

  // apb decode
  wire acc_ph = I_PSEL & I_PENABLE;
  wire wr_en = acc_ph & I_PWRITE;
  wire hit_ctrl = (I_PADDR == `MRS_ADDR_CTRL);
  wire hit_ofs = (I_PADDR == `MRS_ADDR_OFFSET);
  wire hit_acc = (I_PADDR == `MRS_ADDR_ACCEL);
  wire hit_stat = (I_PADDR == `MRS_ADDR_STATUS);
  wire hit_spd = (I_PADDR == `MRS_ADDR_SPEED);
  wire hit_ent = (I_PADDR >= `MRS_ADDR_DATA) && (I_PADDR <= `MRS_ADDR_DATA_END) && (I_PADDR[1:0] == 2'b00);
  wire hit_any = hit_ctrl | hit_ofs | hit_acc | hit_stat | hit_spd | hit_ent;
  wire ro_wr = I_PWRITE & (hit_stat | hit_spd);
  wire [2:0] ent_idx = I_PADDR[4:2];
  wire stopped = (st_q == ST_STOP) || ((st_q == ST_BRAKE) && speed_zero);

  assign O_PREADY = 1'b1;
  assign O_PSLVERR = acc_ph & (~hit_any | ro_wr);

  // input decoding
  wire [2:0] sel_assign = ctrl_q[`MRS_CTRL_SEL_MSB:`MRS_CTRL_SEL_LSB];
  wire [2:0] sel_num = I_SPEED_SELECT & sel_assign;
  wire [N_TL-1:0] tl_assign = ctrl_q[`MRS_CTRL_TL_MSB:`MRS_CTRL_TL_LSB];
  wire tl_on = &(I_TORQUE_LIMIT_ENABLE_INPUT | ~tl_assign);
  wire ext_pwm = ctrl_q[`MRS_CTRL_PWM];
  wire [11:0] ext_code = ext_pwm ? I_EXT_PWM_SPEED : I_EXT_ANALOG_SPEED;
  wire [11:0] ext_tq_code = ext_pwm ? I_EXT_PWM_SPEED : I_EXT_TORQUE_VOLT;

  // selected entry
  wire [31:0] ent = ent_flat[sel_num];
  wire [1:0] s_meth = ent[`MRS_ENT_SM_MSB:`MRS_ENT_SM_LSB];
  wire [1:0] t_meth = ent[`MRS_ENT_TM_MSB:`MRS_ENT_TM_LSB];
  wire [7:0] dec_t = ent[`MRS_ENT_DEC_MSB:`MRS_ENT_DEC_LSB];
  wire set_err = (s_meth == t_meth) && (s_meth != `MRS_M_DIG);

  // operation data entries
  genvar g;
  generate
    for (g = 0; g < N_ENT; g = g + 1)
    begin : g_ent
      localparam [31:0] RST = (g == 0) ? `MRS_ENT0_RST : (g == 1) ? `MRS_ENT1_RST : `MRS_ENTN_RST;
      reg [31:0] ent_q;
      wire wr_me = wr_en & hit_ent & (ent_idx == g);
      always @(posedge I_CLK)
      begin
        if (!I_RSTN)
          ent_q <= RST;
        else if (wr_me)
        begin
          ent_q[`MRS_ENT_TQ_MSB:0] <= I_PWDATA[`MRS_ENT_TQ_MSB:0];
          if (stopped)
            ent_q[`MRS_ENT_TM_MSB:`MRS_ENT_SM_LSB] <= I_PWDATA[`MRS_ENT_TM_MSB:`MRS_ENT_SM_LSB];
        end
      end
      assign ent_flat[g] = ent_q;
    end
  endgenerate

  // control registers
  always @*
  begin
    ofs_w = I_PWDATA[11:0];
    if (!ofs_w[11] && ofs_w > `MRS_OFS_MAX)
      ofs_w = `MRS_OFS_MAX;
    else if (ofs_w[11] && ofs_w < `MRS_OFS_MIN)
      ofs_w = `MRS_OFS_MIN;
  end

  always @(posedge I_CLK)
  begin
    if (!I_RSTN)
    begin
      ctrl_q <= `MRS_CTRL_RST;
      ofs_q <= 12'h000;
      acc_t_q <= `MRS_ACCEL_RST;
    end
    else if (wr_en)
    begin
      if (hit_ctrl)
      begin
        ctrl_q[`MRS_CTRL_DIR] <= I_PWDATA[`MRS_CTRL_DIR];
        ctrl_q[`MRS_CTRL_TL_MSB:`MRS_CTRL_SEL_LSB] <= I_PWDATA[`MRS_CTRL_TL_MSB:`MRS_CTRL_SEL_LSB];
        if (stopped)
          ctrl_q[`MRS_CTRL_PWM] <= I_PWDATA[`MRS_CTRL_PWM];
      end
      if (hit_ofs)
        ofs_q <= ofs_w;
      if (hit_acc)
        acc_t_q <= I_PWDATA[7:0];
    end
  end

  // speed target from the selected method
  wire [23:0] ext_scaled = ext_code * `MRS_SPD_MAX;
  wire [23:0] pot1_scaled = I_INTERNAL_POT_FIRST * `MRS_SPD_MAX;
  wire [23:0] pot2_scaled = I_INTERNAL_POT_SECOND * `MRS_SPD_MAX;
  wire [13:0] ext_ofs = {2'b00, ext_scaled[23:12]} + (ext_pwm ? 14'h0000 : {{2{ofs_q[11]}}, ofs_q});

  always @*
  begin
    case (s_meth)
      `MRS_M_DIG: spd_base = ent[`MRS_ENT_SPD_MSB:`MRS_ENT_SPD_LSB];
      `MRS_M_POT1: spd_base = pot1_scaled[23:12];
      `MRS_M_POT2: spd_base = pot2_scaled[23:12];
      default:
      begin
        if (ext_ofs[13])
          spd_base = 12'h000;
        else if (ext_ofs[12] || ext_ofs[11:0] > `MRS_SPD_MAX)
          spd_base = `MRS_SPD_MAX;
        else
          spd_base = ext_ofs[11:0];
      end
    endcase
    spd_tgt = (spd_base > `MRS_SPD_MAX) ? `MRS_SPD_MAX : spd_base;
  end

  // torque limit from the selected method
  wire [19:0] tq_ext = ext_tq_code * `MRS_TQ_MAX;
  wire [19:0] tq_pot1 = I_INTERNAL_POT_FIRST * `MRS_TQ_MAX;
  wire [19:0] tq_pot2 = I_INTERNAL_POT_SECOND * `MRS_TQ_MAX;

  always @*
  begin
    case (t_meth)
      `MRS_M_DIG: tq_d = ent[`MRS_ENT_TQ_MSB:`MRS_ENT_TQ_LSB];
      `MRS_M_POT1: tq_d = tq_pot1[19:12];
      `MRS_M_POT2: tq_d = tq_pot2[19:12];
      default: tq_d = tq_ext[19:12];
    endcase
    if (tq_d > `MRS_TQ_MAX)
      tq_d = `MRS_TQ_MAX;
  end

  // run and stop state machine
  always @*
  begin
    st_d = st_q;
    case (st_q)
      ST_STOP, ST_RUN, ST_DECEL, ST_BRAKE:
      begin
        if (!I_RUN_PERMIT_INPUT)
          st_d = ST_BRAKE;
        else if (I_RUN_REQUEST && !set_err)
          st_d = ST_RUN;
        else if (I_RUN_REQUEST)
          st_d = ST_BRAKE;
        else if (speed_zero)
          st_d = ST_STOP;
        else if (st_q == ST_BRAKE)
          st_d = ST_BRAKE;
        else
          st_d = ST_DECEL;
      end
      default: st_d = ST_BRAKE;
    endcase
  end

  always @(posedge I_CLK)
  begin
    if (!I_RSTN)
    begin
      st_q <= ST_STOP;
      O_RUN_STATE <= ST_STOP;
      O_BRAKE <= 1'b0;
      O_DIR_CW <= 1'b0;
      O_OP_DATA_NUM <= 3'h0;
      O_TORQUE_LIMIT_PCT <= 8'h00;
      O_TORQUE_LIMIT_ACTIVE <= 1'b0;
      O_SETTING_ERROR <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      O_RUN_STATE <= st_d;
      O_BRAKE <= (st_d == ST_BRAKE);
      O_DIR_CW <= ctrl_q[`MRS_CTRL_DIR] ? I_DIRECTION_INPUT : ~I_DIRECTION_INPUT;
      O_OP_DATA_NUM <= sel_num;
      O_TORQUE_LIMIT_PCT <= tq_d;
      O_TORQUE_LIMIT_ACTIVE <= tl_on;
      O_SETTING_ERROR <= set_err;
    end
  end

  mrs_ramp #(
    .W(12)
  ) u_ramp (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_run(st_q == ST_RUN),
    .i_decel(st_q == ST_DECEL),
    .i_brake(st_q == ST_BRAKE),
    .i_target(spd_tgt),
    .i_acc_t(acc_t_q),
    .i_dec_t(dec_t),
    .o_speed(speed_now),
    .o_zero(speed_zero)
  );
  assign O_SPEED_CMD = speed_now;

  // read data is captured in the setup phase
  always @*
  begin
    rd_d = 32'h00000000;
    if (hit_ctrl)
      rd_d[6:0] = ctrl_q;
    else if (hit_ofs)
      rd_d = {{20{ofs_q[11]}}, ofs_q};
    else if (hit_acc)
      rd_d[7:0] = acc_t_q;
    else if (hit_stat)
      rd_d[10:0] = {O_SETTING_ERROR, O_TORQUE_LIMIT_ACTIVE, O_DIR_CW, O_BRAKE, O_OP_DATA_NUM, 2'b00, O_RUN_STATE};
    else if (hit_spd)
      rd_d[11:0] = speed_now;
    else if (hit_ent)
      rd_d = ent_flat[ent_idx];
  end

  always @(posedge I_CLK)
  begin
    if (!I_RSTN)
      O_PRDATA <= 32'h00000000;
    else if (I_PSEL && !I_PENABLE && !I_PWRITE)
      O_PRDATA <= rd_d;
  end
endmodule // mrs_top

// *** mrs_top_chk.sv ***
`timescale 1ns/100ps
`include "mrs_regs.vh"
module mrs_top_chk #(
  parameter N_TL = 2
) (
  input wire I_CLK,
  input wire I_RSTN,
  input wire I_RUN_REQUEST,
  input wire I_RUN_PERMIT_INPUT,
  input wire [2:0] I_SPEED_SELECT,
  input wire I_DIRECTION_INPUT,
  input wire [N_TL-1:0] I_TORQUE_LIMIT_ENABLE_INPUT,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [7:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  input wire O_PSLVERR,
  input wire [11:0] O_SPEED_CMD,
  input wire O_DIR_CW,
  input wire O_BRAKE,
  input wire [1:0] O_RUN_STATE,
  input wire [2:0] O_OP_DATA_NUM,
  input wire O_TORQUE_LIMIT_ACTIVE,
  input wire O_SETTING_ERROR
);
  reg [6:0] ctrl_q;
  reg [1:0] age_q;
  wire [2:0] sel_x = I_SPEED_SELECT & ctrl_q[4:2];
  wire dir_x = I_DIRECTION_INPUT ~^ ctrl_q[0];
  wire tl_x = &(I_TORQUE_LIMIT_ENABLE_INPUT | ~ctrl_q[6:5]);
  // shadow of the control word, age skips the edges right after reset
  always @(posedge I_CLK)
  begin
    if (!I_RSTN)
    begin
      ctrl_q <= `MRS_CTRL_RST;
      age_q <= 2'h0;
    end
    else
    begin
      if (age_q != 2'h3)
        age_q <= age_q + 2'h1;
      if (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == `MRS_ADDR_CTRL)
        ctrl_q <= I_PWDATA[6:0];
    end
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN || age_q != 2'h3);
  // a run on an entry with a setting error is refused into instant stop
  AST_RUN: assert property (I_RUN_REQUEST && I_RUN_PERMIT_INPUT
    |=> O_RUN_STATE == (O_SETTING_ERROR ? 2'h3 : 2'h1))
    else $error("run state missing");
  AST_STOP: assert property (!I_RUN_PERMIT_INPUT && (I_RUN_REQUEST || O_RUN_STATE != 2'h0)
    |=> O_RUN_STATE == 2'h3 && O_BRAKE)
    else $error("instant stop missing");
  // dropping the request at zero speed leaves nothing to ramp, so it stops
  AST_DEC: assert property (O_RUN_STATE == 2'h1 && !I_RUN_REQUEST && I_RUN_PERMIT_INPUT
    |=> O_RUN_STATE == ($past(O_SPEED_CMD) == 12'h000 ? 2'h0 : 2'h2))
    else $error("decel stop missing");
  AST_DEC_BRK: assert property (O_RUN_STATE == 2'h2 && !I_RUN_PERMIT_INPUT |=> O_RUN_STATE == 2'h3)
    else $error("decel not abandoned");
  AST_ZERO: assert property (O_RUN_STATE == 2'h3 |=> O_SPEED_CMD == 12'h000)
    else $error("speed not zero in instant stop");
  AST_RAMP: assert property (O_RUN_STATE == 2'h2 && I_RUN_PERMIT_INPUT && !I_RUN_REQUEST
    |=> O_SPEED_CMD == $past(O_SPEED_CMD) || O_SPEED_CMD == $past(O_SPEED_CMD) - 12'h001)
    else $error("decel ramp step wrong");
  AST_SEL: assert property (1'b1 |=> O_OP_DATA_NUM == $past(sel_x))
    else $error("data number wrong");
  AST_DIR: assert property (1'b1 |=> O_DIR_CW == $past(dir_x))
    else $error("direction wrong");
  AST_TL: assert property (1'b1 |=> O_TORQUE_LIMIT_ACTIVE == $past(tl_x))
    else $error("torque limit enable wrong");
  AST_SLVERR: assert property (I_PSEL && I_PENABLE && I_PADDR == 8'h14 |-> O_PSLVERR)
    else $error("unmapped access not refused");
endmodule // mrs_top_chk
bind mrs_top mrs_top_chk #(.N_TL(N_TL)) u_chk (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_RUN_REQUEST(I_RUN_REQUEST),
  .I_RUN_PERMIT_INPUT(I_RUN_PERMIT_INPUT), .I_SPEED_SELECT(I_SPEED_SELECT), .I_DIRECTION_INPUT(I_DIRECTION_INPUT),
  .I_TORQUE_LIMIT_ENABLE_INPUT(I_TORQUE_LIMIT_ENABLE_INPUT), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PSLVERR(O_PSLVERR), .O_SPEED_CMD(O_SPEED_CMD),
  .O_DIR_CW(O_DIR_CW), .O_BRAKE(O_BRAKE), .O_RUN_STATE(O_RUN_STATE), .O_OP_DATA_NUM(O_OP_DATA_NUM),
  .O_TORQUE_LIMIT_ACTIVE(O_TORQUE_LIMIT_ACTIVE), .O_SETTING_ERROR(O_SETTING_ERROR));

// *** mrs_top_test.sv ***
`timescale 1ns/100ps
`include "mrs_regs.vh"
module mrs_top_test;
  localparam HOLD = 8;
  logic I_CLK = 1'b0;
  logic I_RSTN = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, chk = 1'b0, p;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdat, r, e;
  logic [5:0] want = 6'h00;
  logic [1:0] tl = 2'h0;
  logic [11:0] ana = 12'h0, pwm = 12'h0, tv = 12'h0, p1 = 12'h0, p2 = 12'h0;
  wire [5:0] lvl;
  wire [31:0] prdata;
  wire pready;
  wire [7:0] tq;
  logic [31:0] expq[$];
  int errors = 0, cmp_count = 0;
  mrs_ctl #(.HOLD(HOLD)) u_ctl (.clk(I_CLK), .rstn(I_RSTN), .i_want(want), .o_lvl(lvl));
  mrs_top dut (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_RUN_REQUEST(lvl[5]), .I_RUN_PERMIT_INPUT(lvl[4]),
    .I_SPEED_SELECT(lvl[2:0]), .I_DIRECTION_INPUT(lvl[3]), .I_TORQUE_LIMIT_ENABLE_INPUT(tl),
    .I_EXT_ANALOG_SPEED(ana), .I_EXT_PWM_SPEED(pwm), .I_EXT_TORQUE_VOLT(tv), .I_INTERNAL_POT_FIRST(p1),
    .I_INTERNAL_POT_SECOND(p2), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(), .O_SPEED_CMD(), .O_DIR_CW(),
    .O_BRAKE(), .O_RUN_STATE(), .O_OP_DATA_NUM(), .O_TORQUE_LIMIT_PCT(tq), .O_TORQUE_LIMIT_ACTIVE(),
    .O_SETTING_ERROR());
  initial forever #10 I_CLK = ~I_CLK;
  function [31:0] st(input [1:0] s, input b, input d, input t, input [2:0] n);
    st = {22'h0, t, d, b, n, 2'h0, s};
  endfunction
  task close_out;
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task apb(input w, input [7:0] a, input [31:0] d, input q, input [31:0] x);
    @(posedge I_CLK);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    chk <= q;
    @(posedge I_CLK);
    penable <= 1'b1;
    if (q)
      expq.push_back(x);
    do @(posedge I_CLK); while (pready !== 1'b1);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input [7:0] a, input [31:0] x);
    apb(1'b0, a, 32'h0, 1'b1, x);
  endtask
  // torque limit is registered: let it settle, then look off the edge
  task tqc(input [19:0] w);
    repeat (2) @(posedge I_CLK);
    @(negedge I_CLK);
    cmp_count++;
    if (tq !== w[19:12])
    begin
      errors++;
      $display("CHECK FAILED torque limit exp %h got %h", w[19:12], tq);
    end
  endtask
  task drv(input [5:0] v);
    want <= v;
    repeat (HOLD + 4) @(posedge I_CLK);
  endtask
  task poll(input [31:0] v);
    int k;
    k = 0;
    rdat = ~v;
    while (rdat !== v && k < 20000)
    begin
      apb(1'b0, `MRS_ADDR_SPEED, 32'h0, 1'b0, 32'h0);
      k++;
    end
    cmp_count++;
    if (rdat !== v)
    begin
      errors++;
      $display("CHECK FAILED speed exp %h got %h", v, rdat);
    end
  endtask
  // compare each completed checked read with the oldest note
  always @(posedge I_CLK)
    if (psel && penable && pready && !pwrite && chk)
    begin
      e = expq.pop_front();
      cmp_count++;
      if (prdata !== e)
      begin
        errors++;
        $display("CHECK FAILED read %h exp %h got %h", paddr, e, prdata);
      end
    end
  initial
  begin
    repeat (95000) @(posedge I_CLK);
    errors++;
    close_out;
  end
  initial
  begin
    r = $urandom(32'hEFD24C5F);
    @(posedge I_CLK);
    ana <= $urandom;
    pwm <= $urandom;
    tv <= $urandom;
    p1 <= $urandom;
    p2 <= $urandom;
    repeat (5) @(posedge I_CLK);
    I_RSTN <= 1'b1;
    rd(`MRS_ADDR_CTRL, 32'h0000000D);
    apb(1'b1, 8'h14, 32'h0, 1'b0, 32'h0);
    apb(1'b1, `MRS_ADDR_DATA + 8'h08, 32'h06401003, 1'b0, 32'h0);
    drv(6'h32);
    rd(`MRS_ADDR_STATUS, st(2'h1, 1'b0, 1'b0, 1'b1, 3'h2));
    poll(32'h3);
    drv(6'h12);
    rd(`MRS_ADDR_STATUS, st(2'h2, 1'b0, 1'b0, 1'b1, 3'h2));
    drv(6'h02);
    rd(`MRS_ADDR_STATUS, st(2'h3, 1'b1, 1'b0, 1'b1, 3'h2));
    rd(`MRS_ADDR_SPEED, 32'h0);
    drv(6'h12);
    rd(`MRS_ADDR_STATUS, st(2'h0, 1'b0, 1'b0, 1'b1, 3'h2));
    drv(6'h32);
    poll(32'h3);
    apb(1'b1, `MRS_ADDR_DATA + 8'h08, 32'hF6401003, 1'b0, 32'h0);
    rd(`MRS_ADDR_DATA + 8'h08, 32'h06401003);
    drv(6'h12);
    poll(32'h0);
    rd(`MRS_ADDR_STATUS, st(2'h0, 1'b0, 1'b0, 1'b1, 3'h2));
    drv(6'h32);
    drv(6'h02);
    rd(`MRS_ADDR_STATUS, st(2'h3, 1'b1, 1'b0, 1'b1, 3'h2));
    drv(6'h0F);
    rd(`MRS_ADDR_STATUS, st(2'h3, 1'b1, 1'b1, 1'b1, 3'h3));
    r = $urandom;
    p = r[0];
    apb(1'b1, `MRS_ADDR_CTRL, {25'h0, 6'h3E, p}, 1'b0, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      r = $urandom;
      tl <= r[1:0];
      drv({2'h0, r[2], k[2:0]});
      rd(`MRS_ADDR_STATUS, st(2'h3, 1'b1, r[2] ~^ p, &r[1:0], k[2:0]));
    end
    apb(1'b1, `MRS_ADDR_DATA + 8'h14, 32'hE0000000, 1'b0, 32'h0);
    apb(1'b1, `MRS_ADDR_DATA + 8'h18, 32'hF0000000, 1'b0, 32'h0);
    drv(6'h05);
    tqc({8'h00, tv} * `MRS_TQ_MAX);
    apb(1'b1, `MRS_ADDR_CTRL, {25'h0, 6'h3F, p}, 1'b0, 32'h0);
    tqc({8'h00, pwm} * `MRS_TQ_MAX);
    apb(1'b1, `MRS_ADDR_OFFSET, 32'h000007FF, 1'b0, 32'h0);
    rd(`MRS_ADDR_OFFSET, 32'h000005DC);
    apb(1'b1, `MRS_ADDR_OFFSET, 32'h00000830, 1'b0, 32'h0);
    rd(`MRS_ADDR_OFFSET, 32'hFFFFFA24);
    drv(6'h36);
    rd(`MRS_ADDR_STATUS, 32'h00000400 | st(2'h3, 1'b1, ~p, &tl, 3'h6));
    close_out;
  end
endmodule // mrs_top_test
